// File: amp_pkg.sv
package amp_pkg;

   // =======================================================================
   // Bus address and transfer counts
   // =======================================================================
   // Seven-bit slave address; with the direction bit clear it reads as D8.
   localparam logic [6:0] DEV_ADDR       = 7'h6C;
   localparam logic [3:0] BYTE_BITS      = 4'h8;
   localparam logic [3:0] LAST_BIT       = 4'h7;
   localparam logic [1:0] WRITE_BYTES    = 2'h2;
   localparam logic [1:0] IDX_FIRST      = 2'h0;
   localparam logic [1:0] IDX_SECOND     = 2'h1;

   // =======================================================================
   // Instruction byte field positions
   // =======================================================================
   localparam int ONE_DIAG_EN      = 6;
   localparam int ONE_OFFSET_EN    = 5;
   localparam int ONE_GAIN_FRONT   = 4;
   localparam int ONE_GAIN_REAR    = 3;
   localparam int ONE_UNMUTE_FRONT = 2;
   localparam int ONE_UNMUTE_REAR  = 1;
   localparam int TWO_TEST_HI      = 6;
   localparam int TWO_TEST_LO      = 5;
   localparam int TWO_STANDBY_OFF  = 4;
   localparam int TWO_LINE_MODE    = 3;

   // =======================================================================
   // Types
   // =======================================================================
   // Per-channel result, laid out as status bits 4 down to 0.
   typedef struct packed {
      logic permanent;
      logic short_load;
      logic open_or_offset;
      logic short_vcc;
      logic short_gnd;
   } chan_diag_t;

   typedef struct packed {
      logic       diag_en;
      logic       offset_en;
      logic       gain12_front;
      logic       gain12_rear;
      logic       unmute_front;
      logic       unmute_rear;
      logic       standby_off;
      logic       line_mode;
      logic [1:0] test_bits;
   } ctrl_t;

   localparam ctrl_t      CTRL_RST    = '0;
   localparam chan_diag_t RESULT_RST  = '0;

endpackage : amp_pkg

// File: pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   // Clock, reset and enable
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             ce,
   // Pins and filtered levels
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level
);

   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs at least one bit");
   end

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] level_r;
   logic [WIDTH-1:0] agree_w;

   // A change is taken only once the second and third stages agree.
   assign agree_w = ~(s2_r ^ s3_r);
   assign level   = level_r;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s1_r    <= {WIDTH{1'b1}};
         s2_r    <= {WIDTH{1'b1}};
         s3_r    <= {WIDTH{1'b1}};
         level_r <= {WIDTH{1'b1}};
      end else if (ce) begin
         s1_r    <= pin_in;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         level_r <= (agree_w & s3_r) | (~agree_w & level_r);
      end
   end

endmodule : pin_sync

// File: amp_diag_status_readback.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Read: address, four status bytes, stop.
// - Byte one bit seven shows thermal warning.
// - Byte one bit six shows cycle finished.
// - Bytes one to four carry four channels.
// - Bit four: turn-on zero, permanent one.
// - Bit three flags a shorted load.
// - Bit two flags open load or offset.
// - Bit one flags short to supply.
// - Bit zero flags short to ground.
// - Byte two bit seven shows offset enable.
// - Byte three bit seven mirrors standby control.
// - Byte three bit six mirrors diagnostic enable.
// - Read after offset run ends the run.
// - Answer address D8; direction bit selects.
// - Each read restarts cycles; previous results returned.
// - First instruction byte field layout.
module amp_diag_status_readback #(
   parameter logic [6:0] SLAVE_ADDR = amp_pkg::DEV_ADDR
) (
   // Clock, reset and enable
   input  wire logic                         clk_sys,
   input  wire logic                         rstn,
   input  wire logic                         ce,
   // Two-wire bus pins
   input  wire logic                         scl_i,
   input  wire logic                         sda_i,
   output logic                              sda_o,
   output logic                              sda_oe,
   // Live results from the fault detectors
   input  wire logic                         thermal_warn,
   input  wire logic                         diag_cycle_done,
   input  wire amp_pkg::chan_diag_t [3:0]    chan_diag,
   // Amplifier control and diagnostic sequencing
   output amp_pkg::ctrl_t                    ctrl,
   output logic                              diag_restart,
   output logic                              offset_stop
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK,
      ST_IGNORE
   } bus_state_t;

   // =======================================================================
   // Pin sampling and bus conditions
   // =======================================================================
   logic [1:0] pins_w;
   logic       scl_q;
   logic       sda_q;
   logic       scl_prev_r;
   logic       sda_prev_r;

   pin_sync #(
      .WIDTH   (2)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .ce      (ce),
      .pin_in  ({scl_i, sda_i}),
      .level   (pins_w)
   );

   assign scl_q = pins_w[1];
   assign sda_q = pins_w[0];

   logic scl_rise_w;
   logic scl_fall_w;
   logic start_w;
   logic stop_w;

   assign scl_rise_w = scl_q & ~scl_prev_r;
   assign scl_fall_w = ~scl_q & scl_prev_r;
   assign start_w    = scl_q & scl_prev_r & sda_prev_r & ~sda_q;
   assign stop_w     = scl_q & scl_prev_r & ~sda_prev_r & sda_q;

   // =======================================================================
   // State
   // =======================================================================
   bus_state_t                 st_r;
   bus_state_t                 st_nxt;
   logic [3:0]                 cnt_r;
   logic [3:0]                 cnt_nxt;
   logic [7:0]                 rx_r;
   logic [7:0]                 rx_nxt;
   logic [7:0]                 tx_r;
   logic [7:0]                 tx_nxt;
   logic                       oe_r;
   logic                       oe_nxt;
   logic [1:0]                 idx_r;
   logic [1:0]                 idx_nxt;
   logic                       seen_r;
   logic                       seen_nxt;
   amp_pkg::ctrl_t             ctrl_r;
   amp_pkg::ctrl_t             ctrl_nxt;
   logic                       restart_r;
   logic                       restart_nxt;
   logic                       offstop_r;
   logic                       offstop_nxt;
   amp_pkg::chan_diag_t [3:0]  results_r;
   amp_pkg::chan_diag_t [3:0]  results_nxt;
   logic [3:0][7:0]            snap_r;
   logic [3:0][7:0]            snap_nxt;

   // =======================================================================
   // Status byte assembly
   // =======================================================================
   logic [3:0][7:0] status_w;
   logic            addr_hit_w;
   logic [1:0]      idx_inc_w;
   logic [7:0]      next_byte_w;

   assign status_w[0] = {thermal_warn,
                         diag_cycle_done,
                         1'b0,
                         results_r[0]};
   assign status_w[1] = {ctrl_r.offset_en,
                         2'b00,
                         results_r[1]};
   assign status_w[2] = {ctrl_r.standby_off,
                         ctrl_r.diag_en,
                         1'b0,
                         results_r[2]};
   assign status_w[3] = {3'b000,
                         results_r[3]};

   // Channel fields follow chan_diag_t: permanent, short load,
   // open load or offset, short to supply, short to ground.

   assign addr_hit_w  = (rx_r[7:1] == SLAVE_ADDR);
   assign idx_inc_w   = 2'(idx_r + 2'h1);
   assign next_byte_w = snap_r[idx_inc_w];

   // =======================================================================
   // Transfer sequencing
   // =======================================================================
   always_comb begin
      st_nxt      = st_r;
      cnt_nxt     = cnt_r;
      rx_nxt      = rx_r;
      tx_nxt      = tx_r;
      oe_nxt      = oe_r;
      idx_nxt     = idx_r;
      seen_nxt    = seen_r;
      ctrl_nxt    = ctrl_r;
      restart_nxt = 1'b0;
      offstop_nxt = 1'b0;
      results_nxt = results_r;
      snap_nxt    = snap_r;
      if (start_w || stop_w) begin
         // A finished read restarts the cycles and latches the new results.
         if (seen_r) begin
            restart_nxt = 1'b1;
            offstop_nxt = ctrl_r.offset_en;
            results_nxt = chan_diag;
            seen_nxt    = 1'b0;
         end
         oe_nxt  = 1'b0;
         cnt_nxt = 4'h0;
         st_nxt  = start_w ? ST_ADDR : ST_IDLE;
      end else begin
         case (st_r)
            ST_ADDR: begin
               if (scl_rise_w) begin
                  rx_nxt  = {rx_r[6:0], sda_q};
                  cnt_nxt = 4'(cnt_r + 4'h1);
               end else if (scl_fall_w && cnt_r == amp_pkg::BYTE_BITS) begin
                  if (addr_hit_w) begin
                     oe_nxt   = 1'b1;
                     idx_nxt  = amp_pkg::IDX_FIRST;
                     snap_nxt = status_w;
                     st_nxt   = ST_ADDR_ACK;
                  end else begin
                     st_nxt = ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall_w) begin
                  cnt_nxt = 4'h0;
                  if (rx_r[0]) begin
                     tx_nxt   = snap_r[amp_pkg::IDX_FIRST];
                     oe_nxt   = ~snap_r[amp_pkg::IDX_FIRST][7];
                     seen_nxt = 1'b1;
                     st_nxt   = ST_RD_BYTE;
                  end else begin
                     oe_nxt = 1'b0;
                     st_nxt = ST_WR_BYTE;
                  end
               end
            end
            ST_WR_BYTE: begin
               if (scl_rise_w) begin
                  rx_nxt  = {rx_r[6:0], sda_q};
                  cnt_nxt = 4'(cnt_r + 4'h1);
               end else if (scl_fall_w && cnt_r == amp_pkg::BYTE_BITS) begin
                  if (idx_r < amp_pkg::WRITE_BYTES) begin
                     oe_nxt  = 1'b1;
                     idx_nxt = idx_inc_w;
                     st_nxt  = ST_WR_ACK;
                     if (idx_r == amp_pkg::IDX_FIRST) begin
                        ctrl_nxt.diag_en      =
                           rx_r[amp_pkg::ONE_DIAG_EN];
                        ctrl_nxt.offset_en    =
                           rx_r[amp_pkg::ONE_OFFSET_EN];
                        ctrl_nxt.gain12_front =
                           rx_r[amp_pkg::ONE_GAIN_FRONT];
                        ctrl_nxt.gain12_rear  =
                           rx_r[amp_pkg::ONE_GAIN_REAR];
                        ctrl_nxt.unmute_front =
                           rx_r[amp_pkg::ONE_UNMUTE_FRONT];
                        ctrl_nxt.unmute_rear  =
                           rx_r[amp_pkg::ONE_UNMUTE_REAR];
                     end else begin
                        ctrl_nxt.standby_off  =
                           rx_r[amp_pkg::TWO_STANDBY_OFF];
                        ctrl_nxt.line_mode    =
                           rx_r[amp_pkg::TWO_LINE_MODE];
                        ctrl_nxt.test_bits    =
                           {rx_r[amp_pkg::TWO_TEST_HI],
                            rx_r[amp_pkg::TWO_TEST_LO]};
                     end
                  end else begin
                     // Bytes past the second are not acknowledged.
                     st_nxt = ST_IGNORE;
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_fall_w) begin
                  oe_nxt  = 1'b0;
                  cnt_nxt = 4'h0;
                  st_nxt  = ST_WR_BYTE;
               end
            end
            ST_RD_BYTE: begin
               if (scl_fall_w) begin
                  if (cnt_r == amp_pkg::LAST_BIT) begin
                     oe_nxt = 1'b0;
                     st_nxt = ST_RD_ACK;
                  end else begin
                     tx_nxt  = {tx_r[6:0], 1'b0};
                     oe_nxt  = ~tx_r[6];
                     cnt_nxt = 4'(cnt_r + 4'h1);
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise_w && sda_q) begin
                  st_nxt = ST_IGNORE;
               end else if (scl_fall_w) begin
                  // Bytes follow in channel order and wrap after the fourth.
                  idx_nxt = idx_inc_w;
                  tx_nxt  = next_byte_w;
                  oe_nxt  = ~next_byte_w[7];
                  cnt_nxt = 4'h0;
                  st_nxt  = ST_RD_BYTE;
               end
            end
            ST_IGNORE: begin
               oe_nxt = 1'b0;
            end
            ST_IDLE: begin
               oe_nxt = 1'b0;
            end
            default: begin
               oe_nxt = 1'b0;
               st_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // =======================================================================
   // Registers
   // =======================================================================
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_r       <= ST_IDLE;
         cnt_r      <= 4'h0;
         rx_r       <= 8'h00;
         tx_r       <= 8'h00;
         oe_r       <= 1'b0;
         idx_r      <= 2'h0;
         seen_r     <= 1'b0;
         ctrl_r     <= amp_pkg::CTRL_RST;
         restart_r  <= 1'b0;
         offstop_r  <= 1'b0;
         results_r  <= {4{amp_pkg::RESULT_RST}};
         snap_r     <= '0;
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else if (ce) begin
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         rx_r       <= rx_nxt;
         tx_r       <= tx_nxt;
         oe_r       <= oe_nxt;
         idx_r      <= idx_nxt;
         seen_r     <= seen_nxt;
         ctrl_r     <= ctrl_nxt;
         restart_r  <= restart_nxt;
         offstop_r  <= offstop_nxt;
         results_r  <= results_nxt;
         snap_r     <= snap_nxt;
         scl_prev_r <= scl_q;
         sda_prev_r <= sda_q;
      end
   end

   // The data pin is open drain: it is only ever pulled low.
   logic sda_low_r;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sda_low_r <= 1'b0;
      end else if (ce) begin
         sda_low_r <= 1'b0;
      end
   end

   assign sda_o        = sda_low_r;
   assign sda_oe       = oe_r;
   assign ctrl         = ctrl_r;
   assign diag_restart = restart_r;
   assign offset_stop  = offstop_r;

endmodule : amp_diag_status_readback

// File: bus_master.sv
`timescale 1ns/10ps
module bus_master (
   // Bus pins
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda_line
);
   // =====================================================================
   // Bus conditions and bits
   // =====================================================================
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Data falls while the clock is high; data is released first.
   task automatic start;
      sda_pull = 1'b0;
      #140;
      scl = 1'b1;
      #200;
      sda_pull = 1'b1;
      #200;
      scl = 1'b0;
      #140;
   endtask : start

   // Data moves only in the 280 ns low phase and is sampled mid-high.
   task automatic bit_io(input logic b, output logic r);
      sda_pull = ~b;
      #140;
      scl = 1'b1;
      #60;
      r = sda_line;
      #60;
      scl = 1'b0;
      #140;
   endtask : bit_io

   // Eight bits MSB first, then a ninth: released to listen, pulled to ack.
   task automatic xbyte(input logic [7:0] d, input logic rel,
                        output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(rel, r);
      ack = ~r;
   endtask : xbyte

   // Data rises while the clock is high; the clock then stands still.
   task automatic stop;
      sda_pull = 1'b1;
      #140;
      scl = 1'b1;
      #200;
      sda_pull = 1'b0;
      #400;
   endtask : stop
endmodule : bus_master

// File: amp_diag_status_readback_sva.sv
`timescale 1ns/10ps
module amp_diag_status_readback_chk (
   // Clock, reset and enable
   input wire logic                      clk_sys,
   input wire logic                      rstn,
   input wire logic                      ce,
   // Bus pins
   input wire logic                      scl_i,
   input wire logic                      sda_i,
   input wire logic                      sda_o,
   input wire logic                      sda_oe,
   // Detector inputs
   input wire logic                      thermal_warn,
   input wire logic                      diag_cycle_done,
   input wire amp_pkg::chan_diag_t [3:0] chan_diag,
   // Control outputs
   input wire amp_pkg::ctrl_t            ctrl,
   input wire logic                      diag_restart,
   input wire logic                      offset_stop
);
   // =====================================================================
   // Assertions
   // =====================================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_drive_held;
      sda_oe [*6];
   endsequence
   sequence s_single_pulse;
      diag_restart ##1 !diag_restart;
   endsequence

   a_reset_quiet:
      assert property (rstn && !$past(rstn) |-> !sda_oe && !diag_restart
         && !offset_stop && ctrl == amp_pkg::CTRL_RST)
      else $error("outputs not cleared by reset");
   a_open_drain:
      assert property (sda_oe |-> !sda_o)
      else $error("data pin driven high");
   a_ack_held:
      assert property ($rose(sda_oe) |-> s_drive_held)
      else $error("data drive shorter than a bit");
   // The drive moves some five cycles after the pin clock falls, so the
   // pin is checked two samples back, while its low phase still lasts.
   a_bit_edge:
      assert property ($changed(sda_oe) |-> $past(!scl_i, 2))
      else $error("data drive moved while bus clock high");
   a_restart_pulse:
      assert property ($rose(diag_restart) |-> s_single_pulse)
      else $error("restart not a single pulse");
   a_restart_at_stop:
      assert property (diag_restart |-> scl_i && !sda_oe)
      else $error("restart outside a stop");
   a_offset_pair:
      assert property (offset_stop |-> diag_restart && ctrl.offset_en)
      else $error("offset stop without restart and enable");
   a_ctrl_at_ack:
      assert property ($changed(ctrl) |-> ##[0:3] sda_oe)
      else $error("control changed away from an acknowledge");
endmodule : amp_diag_status_readback_chk

bind amp_diag_status_readback amp_diag_status_readback_chk i_chk (
   .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .thermal_warn(thermal_warn),
   .diag_cycle_done(diag_cycle_done), .chan_diag(chan_diag), .ctrl(ctrl),
   .diag_restart(diag_restart), .offset_stop(offset_stop)
);

// File: amp_diag_status_readback_bench.sv
`timescale 1ns/10ps
module amp_diag_status_readback_bench;
   // =====================================================================
   // Signals and model state
   // =====================================================================
   logic                      clk_sys;
   logic                      rstn;
   logic                      ce;
   logic                      scl_i;
   logic                      sda_i;
   logic                      sda_o;
   logic                      sda_oe;
   logic                      m_pull;
   logic                      thermal_warn;
   logic                      diag_cycle_done;
   amp_pkg::chan_diag_t [3:0] chan_diag;
   amp_pkg::ctrl_t            ctrl;
   amp_pkg::ctrl_t            ctrl_m;
   logic                      diag_restart;
   logic                      offset_stop;
   logic [19:0]               stored_m;
   logic [31:0]               seed;
   logic [31:0]               pat[4];
   int                        error_cnt;
   int                        checked;
   int                        restart_n;
   int                        offset_n;
   int                        restart_m;
   int                        offset_m;

   assign sda_i = !((sda_oe && !sda_o) || m_pull);

   amp_diag_status_readback i_dut (
      .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .scl_i(scl_i), .sda_i(sda_i),
      .sda_o(sda_o), .sda_oe(sda_oe), .thermal_warn(thermal_warn),
      .diag_cycle_done(diag_cycle_done), .chan_diag(chan_diag), .ctrl(ctrl),
      .diag_restart(diag_restart), .offset_stop(offset_stop)
   );
   bus_master i_master (.scl(scl_i), .sda_pull(m_pull), .sda_line(sda_i));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (diag_restart === 1'b1) restart_n++;
      if (offset_stop === 1'b1) offset_n++;
   end

   // =====================================================================
   // Helpers
   // =====================================================================
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic logic [7:0] exp_byte(input int k);
      case (k)
         0: return {thermal_warn, diag_cycle_done, 1'b0, stored_m[4:0]};
         1: return {ctrl_m.offset_en, 2'b00, stored_m[9:5]};
         2: return {ctrl_m.standby_off, ctrl_m.diag_en, 1'b0,
                    stored_m[14:10]};
         default: return {3'b000, stored_m[19:15]};
      endcase
   endfunction : exp_byte

   task automatic note(input logic ok, input logic [15:0] got, exp);
      checked++;
      if (!ok) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : note

   task automatic cmp_byte(input logic [7:0] got, exp);
      note(got === exp, {8'h00, got}, {8'h00, exp});
   endtask : cmp_byte

   task automatic cmp_ctrl(input amp_pkg::ctrl_t got, exp);
      note(got === exp, {6'h00, got}, {6'h00, exp});
   endtask : cmp_ctrl

   task automatic cmp_ack(input logic got, exp);
      note(got === exp, {15'h0000, got}, {15'h0000, exp});
   endtask : cmp_ack

   task automatic cmp_cnt(input int got, exp);
      note(got === exp, got[15:0], exp[15:0]);
   endtask : cmp_cnt

   task automatic wr(input logic [7:0] b1, b2, input logic hit, extra);
      logic [7:0] q;
      logic       a;
      @(posedge clk_sys);
      i_master.start();
      // With the enable low the true address goes out and no answer comes.
      i_master.xbyte({amp_pkg::DEV_ADDR ^ {6'h00, ~(hit | !ce)}, 1'b0},
                     1'b1, q, a);
      cmp_ack(a, hit);
      i_master.xbyte(b1, 1'b1, q, a);
      cmp_ack(a, hit);
      i_master.xbyte(b2, 1'b1, q, a);
      cmp_ack(a, hit);
      if (extra) begin
         i_master.xbyte(8'hA5, 1'b1, q, a);
         cmp_ack(a, 1'b0);
      end
      i_master.stop();
      if (hit) ctrl_m = amp_pkg::ctrl_t'({b1[6:1], b2[4:3], b2[6:5]});
      cmp_ctrl(ctrl, ctrl_m);
   endtask : wr

   task automatic rd(input int n);
      logic [7:0] q;
      logic       a;
      @(posedge clk_sys);
      i_master.start();
      i_master.xbyte({amp_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a);
      cmp_ack(a, 1'b1);
      for (int k = 0; k < n; k++) begin
         i_master.xbyte(8'hFF, k == n - 1, q, a);
         cmp_byte(q, exp_byte(k % 4));
      end
      i_master.stop();
      restart_m++;
      if (ctrl_m.offset_en) offset_m++;
      stored_m = chan_diag;
      cmp_cnt(restart_n, restart_m);
      cmp_cnt(offset_n, offset_m);
   endtask : rd

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // =====================================================================
   // Sequence of tests
   // =====================================================================
   initial begin
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic [31:0] e;
      seed = 32'h9;
      rstn = 1'b0;
      ce = 1'b1;
      thermal_warn = 1'b0;
      diag_cycle_done = 1'b0;
      chan_diag = '0;
      ctrl_m = amp_pkg::CTRL_RST;
      stored_m = '0;
      pat[0] = 32'h8100EB10;
      pat[1] = 32'hBF00EF00;
      pat[2] = 32'hD926EB10;
      pat[3] = 32'hFF40FF00;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      cmp_ctrl(ctrl, amp_pkg::CTRL_RST);
      for (int i = 0; i < 10; i++) begin
         seed = xs(seed);
         e = (i < 4) ? pat[i] : 32'hFF00FF00;
         b1 = (seed[7:0] & e[31:24]) | e[23:16];
         b2 = (seed[15:8] & e[15:8]) | e[7:0];
         wr(b1, b2, 1'b1, i == 9);
         seed = xs(seed);
         @(posedge clk_sys);
         chan_diag <= seed[19:0];
         thermal_warn <= seed[20];
         diag_cycle_done <= seed[21];
         repeat (20) @(posedge clk_sys);
         rd((i == 6) ? 5 : 4);
         $display("test %0d done", i);
      end
      wr(8'h7E, 8'h7F, 1'b0, 1'b0);
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(8'hFF, 8'hFF, 1'b0, 1'b0);
      @(posedge clk_sys);
      ce <= 1'b1;
      $display("test enable done");
      rd(4);
      $display("test address done");
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      ctrl_m = amp_pkg::CTRL_RST;
      stored_m = '0;
      @(posedge clk_sys);
      rd(4);
      $display("test reset done");
      finish_test();
   end

   initial begin
      #2000000;
      error_cnt++;
      finish_test();
   end
endmodule : amp_diag_status_readback_bench
